/* sim/ebhg_master.sv */
// Model of the outside master that asks for the memory bus.
// Assumes the bench changes GO just after a falling edge.
`timescale 1ns/1ps
`default_nettype none
module ebhg_master (
  input wire logic CLK,
  input wire logic GO,
  input wire logic BUS_GRANT_OUT_N,
  output logic BUS_REQ_N
);
  logic want = 1'b0;
  logic seen = 1'b0;
  initial BUS_REQ_N = 1'b1;
  always @(posedge CLK) begin
    want <= GO;
  end
  // Release waits one clock past the grant
  always @(negedge CLK) begin
    seen <= BUS_GRANT_OUT_N === 1'b0;
    if (want)
      BUS_REQ_N <= 1'b0;
    else if (seen || BUS_GRANT_OUT_N !== 1'b0)
      BUS_REQ_N <= 1'b1;
  end
endmodule : ebhg_master
`default_nettype wire

/* sim/external_bus_hold_grant_bench.sv */
// Bench for the hold/grant block: hand-over, refusal, strobe mapping.
// Assumes the wide port and a 20 MHz port clock.
`timescale 1ns/1ps
`default_nettype none
module external_bus_hold_grant_bench;
  import ebhg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic sel = 1'b0;
  logic inh = 1'b0;
  logic busy = 1'b0;
  logic sdr = 1'b0;
  logic [5:0] ctl = 6'h00;
  logic req_n, row, col, wr, bus_oe, cke, clk_oe, gnt_n, pend;
  int n_mismatch = 0;
  int checked = 0;
  int n;
  ebhg_top dut (.CLK(clk), .RST_N(rst_n), .BUS_REQ_N(req_n), .CLOCK_OUT_FLOAT_SEL(sel),
    .GRANT_INHIBIT(inh), .XFER_BUSY(busy), .SDRAM_ACCESS(sdr), .CTRL_ROW_STROBE(ctl[0]),
    .CTRL_COLUMN_STROBE(ctl[1]), .CTRL_WRITE_STROBE(ctl[2]), .CTRL_ASYNC_OUTPUT_EN(ctl[3]),
    .CTRL_ASYNC_READ_EN(ctl[4]), .CTRL_ASYNC_WRITE_EN(ctl[5]), .ROW_OE_PIN(row),
    .COLUMN_RE_PIN(col), .WRITE_WE_PIN(wr), .BUS_OE(bus_oe), .MEM_CLK_EN(cke),
    .MEMORY_CLOCK_OE(clk_oe), .BUS_GRANT_OUT_N(gnt_n), .HOLD_PENDING(pend));
  ebhg_master master (.CLK(clk), .GO(go), .BUS_GRANT_OUT_N(gnt_n), .BUS_REQ_N(req_n));
  // ************************
  // Shared tasks
  // ************************
  task check(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %b, wanted %b", $time, got, exp);
    end
  endtask : check
  task stop_test;
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // Bounded wait for grant (w=0) or bus drive (w=1) to reach v
  task wait_for(input int w, input logic v);
    n = 0;
    while ((w == 0 ? gnt_n : bus_oe) !== v) begin
      @(negedge clk);
      n++;
      if (n > 30) begin
        n_mismatch++;
        $display("MISMATCH at %0t: wait ran out", $time);
        stop_test();
      end
    end
  endtask : wait_for
  task t_strobe;
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      sdr = k[3];
      ctl = {~k[2:0], k[2:0]};
      #1;
      check({wr, col, row} === (k[3] ? k[2:0] : ~k[2:0]), 1'b1);
    end
    $display("strobe mapping done");
  endtask : t_strobe
  task t_hold(input logic fsel);
    sel = fsel;
    go = 1'b1;
    repeat (2) @(negedge clk);
    check(bus_oe, 1'b1);
    check(clk_oe, 1'b1);
    wait_for(0, 1'b0);
    check(bus_oe, 1'b0);
    check(clk_oe, !fsel);
    check(cke, 1'b0);
    repeat (5) @(negedge clk);
    check(gnt_n | bus_oe, 1'b0);
    go = 1'b0;
    @(negedge clk);
    wait_for(1, 1'b1);
    check(n >= 3 && n <= 7, 1'b1);
    check(clk_oe, 1'b1);
    check(cke, 1'b1);
    repeat (2) @(negedge clk);
    check(gnt_n, 1'b1);
    $display("hand-over done, float select %b", fsel);
  endtask : t_hold
  task t_refuse(input logic b, input logic i);
    busy = b;
    inh = i;
    go = 1'b1;
    repeat (10) @(negedge clk);
    check(gnt_n & bus_oe, 1'b1);
    if (b) check(pend, 1'b1);
    busy = 1'b0;
    if (!i) begin
      wait_for(0, 1'b0);
      check(bus_oe, 1'b0);
    end
    go = 1'b0;
    repeat (3) @(negedge clk);
    inh = 1'b0;
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    $display("refusal done, busy %b inhibit %b", b, i);
  endtask : t_refuse
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_strobe();
    t_hold(1'b1);
    t_hold(1'b0);
    t_refuse(1'b1, 1'b0);
    t_refuse(1'b0, 1'b1);
    stop_test();
  end
endmodule : external_bus_hold_grant_bench
`default_nettype wire

/* src/ebhg_pkg.sv */
// Constants for the external bus hold/grant block.
// Assumes one port clock; every hand-over delay is counted in its periods.
package ebhg_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // Hand-over delays in port-clock periods (E)
  localparam int FLOAT_MIN_E = 2;
  localparam int DRIVE_MIN_E = 2;
  localparam int DRIVE_MAX_E = 7;
  localparam int GRANT_MAX_E = 2;
  localparam int FLOAT_MIN_CYC = FLOAT_MIN_E;
  localparam int DRIVE_MIN_CYC = DRIVE_MIN_E;
  localparam int DRIVE_MAX_CYC = DRIVE_MAX_E;
  localparam int GRANT_MAX_CYC = GRANT_MAX_E;
  localparam int CNT_W = 3;
  // Field widths of the wide and narrow ports
  localparam int WIDE_DATA_W = 64;
  localparam int WIDE_ADDR_W = 20;
  localparam int WIDE_BE_W = 8;
  localparam int NARROW_DATA_W = 16;
  localparam int NARROW_ADDR_W = 20;
  localparam int NARROW_BE_W = 2;
  localparam int CS_W = 4;
  typedef enum logic [4:0] {
    EBHG_OWN = 5'h01,
    EBHG_DRAIN = 5'h02,
    EBHG_FLOAT = 5'h04,
    EBHG_HELD = 5'h08,
    EBHG_RESUME = 5'h10
  } ebhg_state_t;
endpackage : ebhg_pkg

/* src/ebhg_top.sv */
// Bus hand-over logic of an external memory port, with pin drive enables.
// Assumes the request is asynchronous and the memory controller reports busy.
//
// Overview of operation
// - In SDRAM accesses the shared strobe pins act as row, column, write strobes.
// - Bus floats no sooner than two clocks after request falls.
// - Grant goes low within zero to two clocks after bus floats.
// - Bus is driven again two to seven clocks after request rises.
// - Grant returns high within two clocks after bus is driven.
// - Memory clock keeps toggling if float-select is 0, floats if 1.
// - With float-select set, clock floats no sooner than two clocks after request.
// - With float-select set, clock driven two to seven clocks after request rises.
// - Pending transfers finish before the grant is given.
// - Grant inhibit withholds the grant and keeps the bus driven.
// - Wide port float covers selects, byte enables, data, address, strobes, clock enable.
// - Narrow port float covers selects, byte enables, data, address, strobes.
`timescale 1ns/1ps
`default_nettype none
module ebhg_top
  import ebhg_pkg::*;
#(
  parameter bit WIDE_PORT = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic BUS_REQ_N,
  input wire logic CLOCK_OUT_FLOAT_SEL,
  input wire logic GRANT_INHIBIT,
  input wire logic XFER_BUSY,
  input wire logic SDRAM_ACCESS,
  input wire logic CTRL_ROW_STROBE,
  input wire logic CTRL_COLUMN_STROBE,
  input wire logic CTRL_WRITE_STROBE,
  input wire logic CTRL_ASYNC_OUTPUT_EN,
  input wire logic CTRL_ASYNC_READ_EN,
  input wire logic CTRL_ASYNC_WRITE_EN,
  output logic ROW_OE_PIN,
  output logic COLUMN_RE_PIN,
  output logic WRITE_WE_PIN,
  output logic BUS_OE,
  output logic MEM_CLK_EN,
  output logic MEMORY_CLOCK_OE,
  output logic BUS_GRANT_OUT_N,
  output logic HOLD_PENDING
);

  // ********************************
  // Request synchroniser
  // ********************************
  logic req_meta;
  logic req_sync;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_meta <= 1'b1;
      req_sync <= 1'b1;
    end else begin
      req_meta <= BUS_REQ_N;
      req_sync <= req_meta;
    end
  end
  wire req_low = !req_sync;

  // ********************************
  // Hand-over sequencer
  // ********************************
  ebhg_state_t state;
  ebhg_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic clk_float;
  wire cnt_done = (cnt == CNT_W'(0));

  always_comb begin
    next_state = state;
    next_cnt = (cnt_done) ? cnt : cnt - CNT_W'(1);
    case (state)
      EBHG_OWN: begin
        if (req_low && !GRANT_INHIBIT) begin
          next_state = EBHG_DRAIN;
        end
      end
      EBHG_DRAIN: begin
        if (!req_low || GRANT_INHIBIT) begin
          next_state = EBHG_OWN;
        end else if (!XFER_BUSY) begin
          next_state = EBHG_FLOAT;
        end
      end
      EBHG_FLOAT: begin
        next_state = EBHG_HELD;
      end
      EBHG_HELD: begin
        if (!req_low) begin
          next_state = EBHG_RESUME;
          next_cnt = CNT_W'(DRIVE_MIN_CYC - 2);
        end
      end
      EBHG_RESUME: begin
        if (cnt_done) begin
          next_state = EBHG_OWN;
        end
      end
      default: next_state = EBHG_OWN;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= EBHG_OWN;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Clock float choice is frozen at the start of each hold
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      clk_float <= 1'b0;
    end else if (state == EBHG_DRAIN && next_state == EBHG_FLOAT) begin
      clk_float <= CLOCK_OUT_FLOAT_SEL;
    end
  end

  // ********************************
  // Pin drive and strobe mapping
  // ********************************
  wire bus_floated = (state == EBHG_FLOAT) || (state == EBHG_HELD) || (state == EBHG_RESUME);
  assign BUS_OE = !bus_floated;
  assign MEM_CLK_EN = WIDE_PORT ? !bus_floated : 1'b0;
  assign MEMORY_CLOCK_OE = !(bus_floated && clk_float);
  assign HOLD_PENDING = (state == EBHG_DRAIN);
  assign ROW_OE_PIN = SDRAM_ACCESS ? CTRL_ROW_STROBE : CTRL_ASYNC_OUTPUT_EN;
  assign COLUMN_RE_PIN = SDRAM_ACCESS ? CTRL_COLUMN_STROBE : CTRL_ASYNC_READ_EN;
  assign WRITE_WE_PIN = SDRAM_ACCESS ? CTRL_WRITE_STROBE : CTRL_ASYNC_WRITE_EN;

  // Grant follows the pin drive by one clock, so it falls after the float and
  // only rises once the bus is driven again; the master never sees it early
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_GRANT_OUT_N <= 1'b1;
    end else begin
      BUS_GRANT_OUT_N <= !bus_floated;
    end
  end

  // ********************************
  // Parameter checks
  // ********************************
  if (DRIVE_MIN_CYC < 2 || DRIVE_MIN_CYC - 2 >= (1 << CNT_W)) begin : g_bad_resume_cnt
    $error("resume count does not fit the counter");
  end

  // ********************************
  // Checks
  // ********************************
  sequence s_req_fall;
    $fell(BUS_REQ_N);
  endsequence
  sequence s_req_rise;
    $rose(BUS_REQ_N);
  endsequence
  sequence s_hold_start;
    state == EBHG_DRAIN && next_state == EBHG_FLOAT;
  endsequence

  AST_FLOAT_MIN: assert property (@(posedge CLK) disable iff (!RST_N)
    s_req_fall |-> BUS_OE[*2]) else $error("bus floated too early");
  AST_GRANT_AFTER_FLOAT: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(BUS_OE) |-> ##[0:2] !BUS_GRANT_OUT_N) else $error("grant late after float");
  AST_DRIVE_WINDOW: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == EBHG_HELD && BUS_REQ_N && !BUS_GRANT_OUT_N) |-> ##[2:7] BUS_OE)
    else $error("bus not driven in window");
  AST_GRANT_RELEASE: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(BUS_OE) |-> ##[0:2] BUS_GRANT_OUT_N) else $error("grant not released");
  AST_CLK_TOGGLES: assert property (@(posedge CLK) disable iff (!RST_N)
    (!clk_float) |-> MEMORY_CLOCK_OE) else $error("clock floated with select clear");
  AST_CLK_FLOAT_MIN: assert property (@(posedge CLK) disable iff (!RST_N)
    s_req_fall |-> MEMORY_CLOCK_OE[*2]) else $error("clock floated too early");
  AST_CLK_DRIVE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_req_rise ##0 !MEMORY_CLOCK_OE |-> ##[2:7] MEMORY_CLOCK_OE)
    else $error("clock not driven in window");
  AST_NO_GRANT_BUSY: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == EBHG_DRAIN && XFER_BUSY) |=> BUS_OE) else $error("floated during transfer");
  AST_INHIBIT: assert property (@(posedge CLK) disable iff (!RST_N)
    (GRANT_INHIBIT && state == EBHG_OWN) |=> BUS_OE && BUS_GRANT_OUT_N)
    else $error("grant given while inhibited");
  AST_GRANT_SAFE: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(BUS_GRANT_OUT_N) |-> !BUS_OE) else $error("grant while bus driven");
  AST_GRANT_AFTER_DRIVE: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(BUS_GRANT_OUT_N) |-> BUS_OE) else $error("grant released before drive");
  AST_SYNC_DELAY: assert property (@(posedge CLK) disable iff (!RST_N)
    s_req_fall ##0 BUS_OE |-> BUS_OE[*3]) else $error("request used before sync");
  AST_CLK_SEL_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
    s_hold_start ##0 !CLOCK_OUT_FLOAT_SEL |=> MEMORY_CLOCK_OE[*2])
    else $error("clock floated with select clear");
  AST_CLK_SEL_SET: assert property (@(posedge CLK) disable iff (!RST_N)
    s_hold_start ##0 CLOCK_OUT_FLOAT_SEL |=> !MEMORY_CLOCK_OE)
    else $error("clock driven with select set");
  AST_STROBE_SDRAM: assert property (@(posedge CLK) disable iff (!RST_N)
    SDRAM_ACCESS |-> ROW_OE_PIN == CTRL_ROW_STROBE && COLUMN_RE_PIN == CTRL_COLUMN_STROBE
    && WRITE_WE_PIN == CTRL_WRITE_STROBE) else $error("sdram strobe mapping wrong");
  AST_STROBE_ASYNC: assert property (@(posedge CLK) disable iff (!RST_N)
    !SDRAM_ACCESS |-> ROW_OE_PIN == CTRL_ASYNC_OUTPUT_EN && COLUMN_RE_PIN == CTRL_ASYNC_READ_EN
    && WRITE_WE_PIN == CTRL_ASYNC_WRITE_EN) else $error("async strobe mapping wrong");
  AST_CKE_FLOAT: assert property (@(posedge CLK) disable iff (!RST_N)
    !BUS_OE |-> !MEM_CLK_EN) else $error("clock enable driven while floated");
  AST_CKE_DRIVEN: assert property (@(posedge CLK) disable iff (!RST_N)
    BUS_OE |-> MEM_CLK_EN == WIDE_PORT) else $error("clock enable drive wrong");
  AST_NARROW_NO_CKE: assert property (@(posedge CLK) disable iff (!RST_N)
    !WIDE_PORT |-> !MEM_CLK_EN) else $error("narrow port drives clock enable");
  AST_DRAIN_WAITS: assert property (@(posedge CLK) disable iff (!RST_N)
    s_hold_start |-> !XFER_BUSY) else $error("hold started during transfer");
  AST_HOLD_PERSIST: assert property (@(posedge CLK) disable iff (!RST_N)
    (!BUS_GRANT_OUT_N && !req_sync) |=> !BUS_OE) else $error("float dropped early");

endmodule : ebhg_top
`default_nettype wire
